// File: rtl/status_flags_defines.svh
// offsets, field positions and constants of the status flags unit
`ifndef STATUS_FLAGS_DEFINES_SVH
`define STATUS_FLAGS_DEFINES_SVH
`define STATUS_WORD_ADDR    8'hD5
`define FLAG_CARRY_POS      3'd7
`define FLAG_ZERO_POS       3'd6
`define FLAG_SIGN_POS       3'd5
`define FLAG_OVFL_POS       3'd4
`define FLAG_DEC_POS        3'd3
`define FLAG_HALF_POS       3'd2
`define FLAG_FIS_POS        3'd1
`define FLAG_BANK_POS       3'd0
`define STATUS_RESET_VALUE  8'h00
`define WORK_REG_BASE_DEF   8'hC0
`endif

// File: rtl/status_flags_pkg.sv
// types of the status flags unit
package status_flags_pkg;
  typedef enum logic [4:0] {
    OP_NONE        = 5'b00000,
    OP_ADD         = 5'b00001,
    OP_ADC         = 5'b00010,
    OP_SUB         = 5'b00011,
    OP_SBC         = 5'b00100,
    OP_CMP         = 5'b00101,
    OP_AND         = 5'b00110,
    OP_OR          = 5'b00111,
    OP_XOR         = 5'b01000,
    OP_COM         = 5'b01001,
    OP_TEST        = 5'b01010,
    OP_INC         = 5'b01011,
    OP_DEC         = 5'b01100,
    OP_RL          = 5'b01101,
    OP_RLC         = 5'b01110,
    OP_RR          = 5'b01111,
    OP_RRC         = 5'b10000,
    OP_SRA         = 5'b10001,
    OP_DECIMAL_ADJ = 5'b10010,
    OP_CARRY_SET   = 5'b10011,
    OP_CARRY_CLR   = 5'b10100,
    OP_CARRY_INV   = 5'b10101,
    OP_BANK_ZERO   = 5'b10110,
    OP_BANK_ONE    = 5'b10111,
    OP_FAST_IRQ    = 5'b11000,
    OP_IRQ_RETURN  = 5'b11001,
    OP_INCW        = 5'b11010,
    OP_DECW        = 5'b11011
  } alu_op_type;

  typedef struct packed {
    logic       valid;
    alu_op_type op;
    logic [7:0] dst;
    logic [7:0] src;
  } alu_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] result;
    logic [7:0] flags;
  } alu_rsp_type;

  typedef struct packed {
    logic       wr;
    logic       use_work;
    logic [7:0] addr;
    logic [3:0] work_idx;
    logic [7:0] wdata;
  } reg_acc_type;

  typedef struct packed {
    logic        valid;
    logic        dec;
    logic [15:0] word;
  } word_req_type;
endpackage : status_flags_pkg

// File: rtl/cpu_status_flags_unit.sv
// status word, flag update datapath, condition test and pair logic
`timescale 1ns/1ps
`include "status_flags_defines.svh"
module cpu_status_flags_unit #(
  parameter logic [7:0] WORK_REG_BASE = `WORK_REG_BASE_DEF
) (
  input  wire logic                         core_clk_i,
  input  wire logic                         srst_i,
  input  wire status_flags_pkg::alu_req_type alu_req_i,
  input  wire status_flags_pkg::reg_acc_type reg_acc_i,
  input  wire status_flags_pkg::word_req_type word_req_i,
  input  wire logic [3:0]                   cond_code_i,
  output status_flags_pkg::alu_rsp_type      alu_rsp_o,
  output logic [7:0]                        status_word_o,
  output logic [7:0]                        reg_rdata_o,
  output logic [15:0]                       word_result_o,
  output logic                              word_valid_o,
  output logic                              cond_true_o,
  output logic                              irq_block_o,
  output logic                              fast_return_o,
  output logic                              bank_sel_o
);
  import status_flags_pkg::*;

  // zero test shared by every result path
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  // jump condition from the four upper flags only
  function automatic logic cond_eval(input logic [3:0] cc,
                                     input logic [7:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    logic base;
    c = f[`FLAG_CARRY_POS];
    z = f[`FLAG_ZERO_POS];
    s = f[`FLAG_SIGN_POS];
    v = f[`FLAG_OVFL_POS];
    case (cc[2:0])
      3'h0:    base = 1'b0;
      3'h1:    base = s ^ v;
      3'h2:    base = z | (s ^ v);
      3'h3:    base = c | z;
      3'h4:    base = v;
      3'h5:    base = s;
      3'h6:    base = z;
      3'h7:    base = c;
      default: base = 1'b0;
    endcase
    cond_eval = base ^ cc[3];
  endfunction : cond_eval

  logic [7:0]  flags_q;
  logic [7:0]  flags_d;
  logic [7:0]  shadow_q;
  logic [7:0]  res_d;
  logic [7:0]  zs_res;

  wire logic       fl_c = flags_q[`FLAG_CARRY_POS];
  wire logic [7:0] a    = alu_req_i.dst;
  wire logic [7:0] b    = alu_req_i.src;
  wire logic       is_sbc = (alu_req_i.op == OP_SBC);
  wire logic       is_adc = (alu_req_i.op == OP_ADC);

  // adder and subtractor with carry/borrow out of bit 7 and bit 3/4
  wire logic       cin     = (is_adc | is_sbc) ? fl_c : 1'b0;
  wire logic [8:0] add_sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  wire logic [4:0] add_lo  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  wire logic [8:0] sub_dif = {1'b0, a} - {1'b0, b} - {8'h00, cin};
  wire logic [4:0] sub_lo  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
  wire logic       add_ovf = (a[7] == b[7]) && (add_sum[7] != a[7]);
  wire logic       sub_ovf = (a[7] != b[7]) && (sub_dif[7] != a[7]);

  // decimal adjust from stored direction, carry and half carry
  wire logic       da_sub = flags_q[`FLAG_DEC_POS];
  wire logic       da_hi  = fl_c | (!da_sub && (a > 8'h99));
  wire logic       da_lo  = flags_q[`FLAG_HALF_POS] |
                            (!da_sub && (a[3:0] > 4'h9));
  wire logic [7:0] da_cor = {(da_hi ? 4'h6 : 4'h0), (da_lo ? 4'h6 : 4'h0)};
  wire logic [7:0] da_res = da_sub ? (a - da_cor) : (a + da_cor);

  // register select by full address or working index
  wire logic [7:0] sel_addr = reg_acc_i.use_work ?
                     (WORK_REG_BASE | {4'h0, reg_acc_i.work_idx}) :
                     reg_acc_i.addr;
  wire logic       stat_hit = (sel_addr == `STATUS_WORD_ADDR);
  wire logic       stat_wr  = reg_acc_i.wr && stat_hit;

  always_comb
  begin
    flags_d = flags_q;
    res_d   = a;
    zs_res  = 8'h00;
    if (alu_req_i.valid)
    begin
      case (alu_req_i.op)
        OP_ADD, OP_ADC:
        begin
          res_d = add_sum[7:0];
          flags_d[`FLAG_CARRY_POS] = add_sum[8];
          flags_d[`FLAG_OVFL_POS]  = add_ovf;
          flags_d[`FLAG_DEC_POS]   = 1'b0;
          flags_d[`FLAG_HALF_POS]  = add_lo[4];
        end
        OP_SUB, OP_SBC, OP_CMP:
        begin
          res_d = (alu_req_i.op == OP_CMP) ? a : sub_dif[7:0];
          flags_d[`FLAG_CARRY_POS] = sub_dif[8];
          flags_d[`FLAG_OVFL_POS]  = sub_ovf;
          if (alu_req_i.op != OP_CMP)
          begin
            flags_d[`FLAG_DEC_POS]  = 1'b1;
            flags_d[`FLAG_HALF_POS] = sub_lo[4];
          end
        end
        OP_AND, OP_OR, OP_XOR, OP_COM, OP_TEST:
        begin
          case (alu_req_i.op)
            OP_AND:  res_d = a & b;
            OP_OR:   res_d = a | b;
            OP_XOR:  res_d = a ^ b;
            OP_COM:  res_d = ~a;
            default: res_d = a & b;
          endcase
          flags_d[`FLAG_OVFL_POS] = 1'b0;
        end
        OP_INC:
        begin
          res_d = a + 8'h01;
          flags_d[`FLAG_OVFL_POS] = (a == 8'h7F);
        end
        OP_DEC:
        begin
          res_d = a - 8'h01;
          flags_d[`FLAG_OVFL_POS] = (a == 8'h80);
        end
        OP_RL, OP_RLC:
        begin
          res_d = {a[6:0], (alu_req_i.op == OP_RLC) ? fl_c : a[7]};
          flags_d[`FLAG_CARRY_POS] = a[7];
          flags_d[`FLAG_OVFL_POS]  = a[7] ^ a[6];
        end
        OP_RR, OP_RRC:
        begin
          res_d = {(alu_req_i.op == OP_RRC) ? fl_c : a[0], a[7:1]};
          flags_d[`FLAG_CARRY_POS] = a[0];
          flags_d[`FLAG_OVFL_POS]  = res_d[7] ^ a[7];
        end
        OP_SRA:
        begin
          res_d = {a[7], a[7:1]};
          flags_d[`FLAG_CARRY_POS] = a[0];
          flags_d[`FLAG_OVFL_POS]  = 1'b0;
        end
        OP_DECIMAL_ADJ:
        begin
          res_d = da_res;
          flags_d[`FLAG_CARRY_POS] = da_hi;
        end
        OP_CARRY_SET: flags_d[`FLAG_CARRY_POS] = 1'b1;
        OP_CARRY_CLR: flags_d[`FLAG_CARRY_POS] = 1'b0;
        OP_CARRY_INV: flags_d[`FLAG_CARRY_POS] = ~fl_c;
        OP_BANK_ZERO: flags_d[`FLAG_BANK_POS]  = 1'b0;
        OP_BANK_ONE:  flags_d[`FLAG_BANK_POS]  = 1'b1;
        OP_FAST_IRQ:  flags_d[`FLAG_FIS_POS]   = 1'b1;
        OP_IRQ_RETURN:
        begin
          // fast return restores the saved word with the bit cleared
          if (flags_q[`FLAG_FIS_POS])
          begin
            flags_d = shadow_q;
            flags_d[`FLAG_FIS_POS] = 1'b0;
          end
        end
        default: flags_d = flags_q;
      endcase
      case (alu_req_i.op)
        OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CMP, OP_AND, OP_OR, OP_XOR,
        OP_COM, OP_TEST, OP_INC, OP_DEC, OP_RL, OP_RLC, OP_RR, OP_RRC,
        OP_SRA, OP_DECIMAL_ADJ:
        begin
          // compare keeps dst, but its flags follow the difference
          zs_res = (alu_req_i.op == OP_CMP) ? sub_dif[7:0] : res_d;
          flags_d[`FLAG_ZERO_POS] = is_zero(zs_res);
          flags_d[`FLAG_SIGN_POS] = zs_res[7];
        end
        default: flags_d[`FLAG_ZERO_POS] = flags_d[`FLAG_ZERO_POS];
      endcase
    end
    // any valid alu request wins over a plain write in the same cycle
    if (stat_wr && !alu_req_i.valid)
    begin
      flags_d = reg_acc_i.wdata;
    end
  end

  // 16-bit word step, carry crossing into the upper byte
  wire logic [15:0] word_next = word_req_i.dec ?
                      (word_req_i.word - 16'h0001) :
                      (word_req_i.word + 16'h0001);

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      flags_q       <= `STATUS_RESET_VALUE;
      shadow_q      <= `STATUS_RESET_VALUE;
      alu_rsp_o     <= '0;
      reg_rdata_o   <= 8'h00;
      word_result_o <= 16'h0000;
      word_valid_o  <= 1'b0;
      cond_true_o   <= 1'b0;
    end
    else
    begin
      flags_q <= flags_d;
      if (alu_req_i.valid && alu_req_i.op == OP_FAST_IRQ)
      begin
        shadow_q <= flags_q;
      end
      alu_rsp_o.valid  <= alu_req_i.valid;
      alu_rsp_o.result <= res_d;
      alu_rsp_o.flags  <= flags_d;
      reg_rdata_o      <= stat_hit ? flags_q : 8'h00;
      word_result_o    <= word_next;
      word_valid_o     <= word_req_i.valid;
      cond_true_o      <= cond_eval(cond_code_i, flags_d);
    end
  end

  assign status_word_o = flags_q;
  assign irq_block_o   = flags_q[`FLAG_FIS_POS];
  assign fast_return_o = flags_q[`FLAG_FIS_POS];
  assign bank_sel_o    = flags_q[`FLAG_BANK_POS];

  carry_set_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    alu_req_i.valid && alu_req_i.op == OP_CARRY_SET && !stat_wr
    |=> status_word_o[7] && status_word_o[6:0] == $past(flags_q[6:0]))
    else $error("carry set disturbed");
  zero_flag_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    alu_req_i.valid && alu_req_i.op == OP_AND
    |=> status_word_o[6] == (alu_rsp_o.result == 8'h00) && !status_word_o[4])
    else $error("and flags wrong");
  sign_flag_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    alu_req_i.valid && alu_req_i.op == OP_XOR
    |=> status_word_o[5] == alu_rsp_o.result[7])
    else $error("sign flag wrong");
  add_carry_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    alu_req_i.valid && alu_req_i.op == OP_ADD
    |=> status_word_o[7] == ({1'b0, $past(a)} + {1'b0, $past(b)} > 9'h0FF))
    else $error("add carry wrong");
  shift_carry_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    alu_req_i.valid && alu_req_i.op == OP_RR
    |=> status_word_o[7] == $past(a[0]))
    else $error("rotate carry wrong");
  fast_irq_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    alu_req_i.valid && alu_req_i.op == OP_FAST_IRQ
    |=> irq_block_o ##1 (irq_block_o || $past(alu_req_i.op) == OP_IRQ_RETURN))
    else $error("fast irq bit wrong");
  bank_sel_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    alu_req_i.valid && alu_req_i.op == OP_BANK_ONE |=> bank_sel_o)
    else $error("bank one not set");
  word_step_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    word_req_i.valid && !word_req_i.dec && word_req_i.word == 16'h00FF
    |=> word_valid_o && word_result_o == 16'h0100)
    else $error("word carry lost");
  plain_write_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    stat_wr && !alu_req_i.valid |=> status_word_o == $past(reg_acc_i.wdata))
    else $error("status write lost");
  cmp_zero_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    alu_req_i.valid && alu_req_i.op == OP_CMP
    |=> status_word_o[6] == ($past(a) == $past(b)))
    else $error("compare zero wrong");
  logic_ovfl_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    alu_req_i.valid && (alu_req_i.op == OP_OR || alu_req_i.op == OP_COM)
    |=> !status_word_o[4])
    else $error("logic overflow set");
  half_carry_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    alu_req_i.valid && alu_req_i.op == OP_ADD
    |=> status_word_o[2] ==
        ({1'b0, $past(a[3:0])} + {1'b0, $past(b[3:0])} > 5'h0F))
    else $error("half carry wrong");
  dec_dir_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    alu_req_i.valid && (alu_req_i.op == OP_SUB || alu_req_i.op == OP_SBC)
    |=> status_word_o[3])
    else $error("subtract direction lost");
  inc_ovfl_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    alu_req_i.valid && alu_req_i.op == OP_INC && a == 8'h7F
    |=> status_word_o[4] && status_word_o[5])
    else $error("increment overflow wrong");
  cond_fixed_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cond_code_i[2:0] == 3'h0
    |=> cond_true_o == $past(cond_code_i[3]))
    else $error("fixed condition wrong");
endmodule : cpu_status_flags_unit

// File: testbench/seq_model.sv
// sequencer model issuing alu and register requests one cycle late
`timescale 1ns/1ps
module seq_model (
  input  wire logic                          core_clk_i,
  input  wire logic                          srst_i,
  input  wire status_flags_pkg::alu_req_type cmd_i,
  input  wire status_flags_pkg::reg_acc_type acc_i,
  input  wire logic                          clash_i,
  output status_flags_pkg::alu_req_type      alu_req_o,
  output status_flags_pkg::reg_acc_type      reg_acc_o
);
  import status_flags_pkg::*;
  logic acc_ok;
  // a valid alu request and any register write go out together only on demand
  assign acc_ok = !(cmd_i.valid && acc_i.wr) || clash_i;
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      alu_req_o <= '0;
      reg_acc_o <= '0;
    end
    else
    begin
      alu_req_o <= cmd_i;
      reg_acc_o <= acc_ok ? acc_i : '0;
    end
  end
endmodule : seq_model

// File: testbench/test_cpu_status_flags_unit.sv
// self-checking bench of the status flags unit
`timescale 1ns/1ps
module test_cpu_status_flags_unit;
  import status_flags_pkg::*;
  typedef struct packed {
    alu_op_type op;
    logic [7:0] dst, src, res, flg;
    logic       has_res;
  } row_type;
  logic         core_clk_i = 1'b0;
  logic         srst_i     = 1'b1;
  logic         clash      = 1'b0;
  alu_req_type  cmd        = '0;
  reg_acc_type  acc        = '0;
  word_req_type wreq       = '0;
  logic [3:0]   cond       = 4'h0;
  alu_req_type  alu_req;
  reg_acc_type  reg_acc;
  alu_rsp_type  rsp;
  logic [7:0]   status, rdata, val;
  logic [15:0]  wres;
  logic         wval, ctrue, blk, fret, bank;
  int           err_total = 0;
  int           n_tests   = 0;
  row_type rows [29] = '{
    '{OP_ADD, 8'h7F, 8'h01, 8'h80, 8'h34, 1'b1},
    '{OP_ADD, 8'hFF, 8'h01, 8'h00, 8'hC4, 1'b1},
    '{OP_ADC, 8'h10, 8'h03, 8'h14, 8'h00, 1'b1},
    '{OP_SUB, 8'h00, 8'h01, 8'hFF, 8'hAC, 1'b1},
    '{OP_SUB, 8'h80, 8'h01, 8'h7F, 8'h1C, 1'b1},
    '{OP_AND, 8'hF0, 8'h0F, 8'h00, 8'h4C, 1'b1},
    '{OP_OR, 8'h80, 8'h01, 8'h81, 8'h2C, 1'b1},
    '{OP_XOR, 8'hFF, 8'hFF, 8'h00, 8'h4C, 1'b1},
    '{OP_SBC, 8'h10, 8'h01, 8'h0F, 8'h0C, 1'b1},
    '{OP_CMP, 8'h05, 8'h05, 8'h00, 8'h4C, 1'b0},
    '{OP_COM, 8'h0F, 8'h00, 8'hF0, 8'h2C, 1'b1},
    '{OP_TEST, 8'hF0, 8'h0F, 8'h00, 8'h4C, 1'b0},
    '{OP_INC, 8'h7F, 8'h00, 8'h80, 8'h3C, 1'b1},
    '{OP_DEC, 8'h80, 8'h00, 8'h7F, 8'h1C, 1'b1},
    '{OP_ADD, 8'h15, 8'h27, 8'h3C, 8'h00, 1'b1},
    '{OP_DECIMAL_ADJ, 8'h3C, 8'h00, 8'h42, 8'h00, 1'b1},
    '{OP_SUB, 8'h42, 8'h15, 8'h2D, 8'h0C, 1'b1},
    '{OP_DECIMAL_ADJ, 8'h2D, 8'h00, 8'h27, 8'h0C, 1'b1},
    '{OP_CMP, 8'h27, 8'h27, 8'h00, 8'h4C, 1'b0},
    '{OP_CARRY_SET, 8'h00, 8'h00, 8'h00, 8'hCC, 1'b0},
    '{OP_CARRY_CLR, 8'h00, 8'h00, 8'h00, 8'h4C, 1'b0},
    '{OP_CARRY_INV, 8'h00, 8'h00, 8'h00, 8'hCC, 1'b0},
    '{OP_RL, 8'h80, 8'h00, 8'h01, 8'h9C, 1'b1},
    '{OP_RR, 8'h01, 8'h00, 8'h80, 8'hBC, 1'b1},
    '{OP_SRA, 8'h81, 8'h00, 8'hC0, 8'hAC, 1'b1},
    '{OP_RLC, 8'h00, 8'h00, 8'h01, 8'h0C, 1'b1},
    '{OP_RRC, 8'h01, 8'h00, 8'h00, 8'hCC, 1'b1},
    '{OP_BANK_ONE, 8'h00, 8'h00, 8'h00, 8'hCD, 1'b0},
    '{OP_BANK_ZERO, 8'h00, 8'h00, 8'h00, 8'hCC, 1'b0}};

  seq_model seq_model_inst (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .cmd_i(cmd), .acc_i(acc), .clash_i(clash), .alu_req_o(alu_req),
    .reg_acc_o(reg_acc));
  cpu_status_flags_unit #(.WORK_REG_BASE(8'hD0)) cpu_status_flags_unit_inst (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .alu_req_i(alu_req),
    .reg_acc_i(reg_acc), .word_req_i(wreq), .cond_code_i(cond),
    .alu_rsp_o(rsp), .status_word_o(status), .reg_rdata_o(rdata),
    .word_result_o(wres), .word_valid_o(wval), .cond_true_o(ctrue),
    .irq_block_o(blk), .fast_return_o(fret), .bank_sel_o(bank));

  initial
  begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // request goes through the sequencer model, answer checked after it lands
  task automatic issue(input alu_req_type c, input reg_acc_type a);
    @(posedge core_clk_i);
    cmd <= c;
    acc <= a;
    @(posedge core_clk_i);
    cmd <= '0;
    acc.wr <= 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask : issue

  task automatic op(input alu_op_type o, input logic [7:0] d, s);
    issue('{1'b1, o, d, s}, '0);
  endtask : op

  initial
  begin
    repeat (2000) @(posedge core_clk_i);
    err_total++;
    final_report();
  end

  initial
  begin
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    #1;
    chk(status, 8'h00); // reset value
    foreach (rows[i])
    begin
      op(rows[i].op, rows[i].dst, rows[i].src);
      chk(rsp.valid, 1'b1);
      if (rows[i].has_res)
        chk(rsp.result, rows[i].res);
      chk(rsp.flags, rows[i].flg);
      chk(status, rows[i].flg);
    end
    op(OP_FAST_IRQ, 8'h00, 8'h00);
    chk({status, blk, fret}, {8'hCE, 2'b11});
    op(OP_ADD, 8'h01, 8'h01);
    chk(status, 8'h02);
    op(OP_IRQ_RETURN, 8'h00, 8'h00);
    chk({status, blk, fret}, {8'hCC, 2'b00});
    op(OP_IRQ_RETURN, 8'h00, 8'h00);
    chk(status, 8'hCC);
    // condition table must ignore the bcd bits, so two words share one table
    for (int j = 0; j < 2; j++)
    begin
      val = (j == 0) ? 8'h81 : 8'h8D;
      issue('0, '{1'b1, j == 0, (j == 0) ? 8'h00 : 8'hD5, 4'h5, val});
      chk({status, bank}, {val, 1'b1});
      for (int k = 0; k < 16; k++)
      begin
        @(posedge core_clk_i);
        cond <= 4'(k);
        @(posedge core_clk_i);
        #1;
        chk(ctrue, 16'h7788 >> k & 16'h1);
      end
    end
    chk(rdata, 8'h8D);
    issue('0, '{1'b0, 1'b0, 8'h10, 4'h0, 8'hFF});
    chk({rdata, status}, {8'h00, 8'h8D});
    clash <= 1'b1;
    issue('{1'b1, OP_ADD, 8'h01, 8'h01}, '{1'b1, 1'b0, 8'hD5, 4'h0, 8'hFF});
    chk(status, 8'h01);
    clash <= 1'b0;
    @(posedge core_clk_i);
    wreq <= '{1'b1, 1'b0, 16'h00FF};
    @(posedge core_clk_i);
    wreq <= '{1'b1, 1'b1, 16'h0100};
    #1;
    chk({wval, wres}, {1'b1, 16'h0100});
    @(posedge core_clk_i);
    wreq.valid <= 1'b0;
    #1;
    chk({wval, wres}, {1'b1, 16'h00FF});
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    @(posedge core_clk_i);
    srst_i <= 1'b0;
    #1;
    chk({status, wval}, 9'h000); // mid-run reset
    final_report();
  end
endmodule : test_cpu_status_flags_unit
